// >>> common/tcc_pkg.sv
// package: register map, field layout, mode decoding and carriers of the capture/compare block
package tcc_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FILTER_SAMPLES = 4;
  // register byte addresses, one 32-bit word each, data in the low byte lane except the control word
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CAP_LO = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CAP_HI = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_CMPB_LO = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_CMPB_HI = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_FORCE = 8'h28;
  // control word fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FILT_BIT = 4;
  localparam int CTRL_EDGE_BIT = 5;
  localparam int CTRL_CSEL_BIT = 6;
  localparam int CTRL_COMA_LSB = 8;
  localparam int CTRL_COMB_LSB = 10;
  localparam int CTRL_IEN_LSB = 12;
  // status and force word fields
  localparam int FLAG_CAP_BIT = 0;
  localparam int FLAG_CMP_LSB = 1;
  localparam int FLAG_OUT_LSB = 4;
  localparam int FORCE_LSB = 0;
  // compare output actions
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // ceiling constants
  localparam logic [CNT_W-1:0] TOP_8BIT = 16'h00FF;
  localparam logic [CNT_W-1:0] TOP_9BIT = 16'h01FF;
  localparam logic [CNT_W-1:0] TOP_10BIT = 16'h03FF;
  localparam logic [CNT_W-1:0] TOP_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] BOTTOM = 16'h0000;
  localparam logic OUT_STATE_RESET = 1'b0;
  typedef struct packed {
    logic [2:0] irqEnable;
    logic [1:0] comModeB;
    logic [1:0] comModeA;
    logic compSelect;
    logic edgeRising;
    logic filterEnable;
    logic [3:0] waveMode;
  } tcc_ctrl_t;
  localparam tcc_ctrl_t CTRL_RESET = tcc_ctrl_t'(14'h0000);
  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [ADDR_W-1:0] haddr;
  } tcc_ahb_req_t;
  typedef struct packed {
    logic topFromCap;
    logic topFromCmpA;
    logic pwm;
    logic fast;
    logic updBottom;
    logic [CNT_W-1:0] fixedTop;
  } tcc_mode_t;
  // waveform mode decoding
  function automatic tcc_mode_t decodeMode(input logic [3:0] m);
    tcc_mode_t d;
    d.topFromCap = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
    d.topFromCmpA = (m == 4'h4) || (m == 4'h9) || (m == 4'hB) || (m == 4'hF);
    d.pwm = !((m == 4'h0) || (m == 4'h4) || (m == 4'hC) || (m == 4'hD));
    d.fast = (m == 4'h5) || (m == 4'h6) || (m == 4'h7) || (m == 4'hE) || (m == 4'hF);
    d.updBottom = (m == 4'h8) || (m == 4'h9);
    case (m)
      4'h1, 4'h5: d.fixedTop = TOP_8BIT;
      4'h2, 4'h6: d.fixedTop = TOP_9BIT;
      4'h3, 4'h7: d.fixedTop = TOP_10BIT;
      default: d.fixedTop = TOP_MAX;
    endcase
    return d;
  endfunction
endpackage

// >>> hdl/tcc_capture_compare.sv
// capture unit, two compare channels and AHB-Lite register slave of the 16-bit timer
// Contract
// - selected edge of trigger source copies full counter into capture value
// - capture flag rises in the same cycle as the copy
// - enabled capture flag requests interrupt; cleared by service or writing one
// - reading capture low byte loads high byte into shared latch, read later
// - capture value writable only in capture-ceiling modes, high byte first
// - comparator select picks comparator output; switching may capture, software clears flag
// - filter needs four equal samples, adds four clocks, ignores prescaler
// - capture input stays active except in capture-ceiling modes
// - capture pin sampled whoever drives it, so software can trigger
// - every capture overwrites the capture value, no overrun guard
// - enabled compare flag requests interrupt; cleared by service or writing one
// - channel A compare value can be the counter ceiling
// - compare double buffered in PWM modes, loaded at ceiling or zero
// - CPU reaches buffer or compare register; reads bypass high latch
// - compare high byte goes to latch; low write loads all sixteen bits
// - force in non-PWM modes acts like match without flag or counter change
// - counter write blocks compare matches on the next timer tick
// - counter written to variable ceiling misses ceiling match, counts on
// - compare output state kept across waveform mode changes
// - compare output mode bits act immediately, unbuffered
// - CPU counter write beats simultaneous clear or count
// - reset clears each compare output state
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tcc_capture_compare (
  input wire logic clk,
  input wire logic srst,
  input wire tcc_pkg::tcc_ahb_req_t ahbReq,
  input wire logic hready,
  input wire logic [tcc_pkg::DATA_W-1:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [tcc_pkg::DATA_W-1:0] hrdata,
  input wire logic [tcc_pkg::CNT_W-1:0] counterValue,
  input wire logic timerTick,
  input wire logic capturePin,
  input wire logic comparatorOutput,
  input wire logic [2:0] irqAck,
  output logic [2:0] irqRequest,
  output logic counterWriteStb,
  output logic [tcc_pkg::CNT_W-1:0] counterWriteValue,
  output logic ceilingMatch,
  output logic [1:0] compareMatch,
  output logic [1:0] compareOutputState
);
  import tcc_pkg::*;
  logic pinMeta_r;
  logic pinSync_r;
  logic cmpMeta_r;
  logic cmpSync_r;
  logic trigRaw;
  logic trigFilt;
  logic trig;
  logic trigPrev_r;
  logic inputOn;
  logic capEvent;
  tcc_ctrl_t ctrl_r;
  tcc_mode_t mode;
  logic addrAccept;
  logic rdAccept;
  logic dpWrite_r;
  logic [ADDR_W-1:0] dpAddr_r;
  logic [DATA_W-1:0] hrdata_r;
  logic [DATA_W-1:0] rdNxt;
  logic [7:0] hiLatch_r;
  logic [CNT_W-1:0] wrLowValue;
  logic wrHi;
  logic rdCapLo;
  logic rdCntLo;
  logic [CNT_W-1:0] capValue_r;
  logic capFlag_r;
  logic capClr;
  logic cntWrStb_r;
  logic [CNT_W-1:0] cntWrVal_r;
  logic block_r;
  logic [CNT_W-1:0] topValue;
  logic atTop;
  logic atBottom;
  logic [CNT_W-1:0] cmpValue [2];
  logic [CNT_W-1:0] cmpRead [2];
  logic [1:0] cmpFlag;
  logic [1:0] cmpMatch;
  logic [1:0] cmpOut;

  // two-stage synchronisers for the capture pin and comparator output
  always_ff @(posedge clk) begin
    if (srst) begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
      cmpMeta_r <= 1'b0;
      cmpSync_r <= 1'b0;
    end else begin
      pinMeta_r <= capturePin;
      pinSync_r <= pinMeta_r;
      cmpMeta_r <= comparatorOutput;
      cmpSync_r <= cmpMeta_r;
    end
  end

  // trigger source, optional filter and edge detection
  assign mode = decodeMode(ctrl_r.waveMode);
  assign trigRaw = ctrl_r.compSelect ? cmpSync_r : pinSync_r;
  tcc_noise_filter #(
    .SAMPLES(FILTER_SAMPLES)
  ) u_filter (
    .clk(clk),
    .srst(srst),
    .sampleIn(trigRaw),
    .filtOut(trigFilt)
  );
  assign trig = ctrl_r.filterEnable ? trigFilt : trigRaw;
  assign inputOn = !mode.topFromCap;
  assign capEvent = inputOn && (trig != trigPrev_r) && (trig == ctrl_r.edgeRising);

  // previous trigger level for the edge detector
  always_ff @(posedge clk) begin
    if (srst) trigPrev_r <= 1'b0;
    else trigPrev_r <= trig;
  end

  // AHB-Lite address phase capture, zero wait states
  assign addrAccept = ahbReq.hsel && ahbReq.htrans[1] && hready;
  assign rdAccept = addrAccept && !ahbReq.hwrite;
  assign rdCapLo = rdAccept && (ahbReq.haddr == ADDR_CAP_LO);
  assign rdCntLo = rdAccept && (ahbReq.haddr == ADDR_CNT_LO);
  always_ff @(posedge clk) begin
    if (srst) begin
      dpWrite_r <= 1'b0;
      dpAddr_r <= '0;
    end else begin
      dpWrite_r <= addrAccept && ahbReq.hwrite;
      dpAddr_r <= ahbReq.haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // shared high-byte latch, a read of a low byte wins over a high-byte write
  assign wrHi = dpWrite_r && ((dpAddr_r == ADDR_CNT_HI) || (dpAddr_r == ADDR_CAP_HI) ||
    (dpAddr_r == ADDR_CMPA_HI) || (dpAddr_r == ADDR_CMPB_HI));
  always_ff @(posedge clk) begin
    if (srst) hiLatch_r <= 8'h00;
    else if (rdCapLo) hiLatch_r <= capValue_r[15:8];
    else if (rdCntLo) hiLatch_r <= counterValue[15:8];
    else if (wrHi) hiLatch_r <= hwdata[7:0];
  end
  assign wrLowValue = {hiLatch_r, hwdata[7:0]};

  // control register
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= CTRL_RESET;
    end else if (dpWrite_r && dpAddr_r == ADDR_CTRL) begin
      ctrl_r.waveMode <= hwdata[CTRL_MODE_LSB +: 4];
      ctrl_r.filterEnable <= hwdata[CTRL_FILT_BIT];
      ctrl_r.edgeRising <= hwdata[CTRL_EDGE_BIT];
      ctrl_r.compSelect <= hwdata[CTRL_CSEL_BIT];
      ctrl_r.comModeA <= hwdata[CTRL_COMA_LSB +: 2];
      ctrl_r.comModeB <= hwdata[CTRL_COMB_LSB +: 2];
      ctrl_r.irqEnable <= hwdata[CTRL_IEN_LSB +: 3];
    end
  end

  // capture value: every event overwrites, CPU write only as ceiling
  always_ff @(posedge clk) begin
    if (srst) capValue_r <= '0;
    else if (capEvent) capValue_r <= counterValue;
    else if (dpWrite_r && dpAddr_r == ADDR_CAP_LO && mode.topFromCap) begin
      capValue_r <= wrLowValue;
    end
  end

  // capture flag, an event wins over a clear
  assign capClr = (dpWrite_r && dpAddr_r == ADDR_FLAGS && hwdata[FLAG_CAP_BIT]) || irqAck[0];
  always_ff @(posedge clk) begin
    if (srst) capFlag_r <= 1'b0;
    else if (capEvent) capFlag_r <= 1'b1;
    else if (capClr) capFlag_r <= 1'b0;
  end

  // counter write strobe to the counter, which lets it override count and clear
  always_ff @(posedge clk) begin
    if (srst) begin
      cntWrStb_r <= 1'b0;
      cntWrVal_r <= '0;
    end else begin
      cntWrStb_r <= dpWrite_r && dpAddr_r == ADDR_CNT_LO;
      if (dpWrite_r && dpAddr_r == ADDR_CNT_LO) cntWrVal_r <= wrLowValue;
    end
  end
  assign counterWriteStb = cntWrStb_r;
  assign counterWriteValue = cntWrVal_r;

  // match blocking after a counter write, held until a timer tick, stopped or not
  always_ff @(posedge clk) begin
    if (srst) block_r <= 1'b0;
    else if (cntWrStb_r) block_r <= 1'b1;
    else if (timerTick) block_r <= 1'b0;
  end

  // ceiling selection and ceiling match towards the counter
  assign topValue = mode.topFromCap ? capValue_r :
    (mode.topFromCmpA ? cmpValue[0] : mode.fixedTop);
  assign atTop = counterValue == topValue;
  assign atBottom = counterValue == BOTTOM;
  assign ceilingMatch = timerTick && atTop && !block_r;

  // the two compare channels
  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam logic [ADDR_W-1:0] LO_ADDR = (i == 0) ? ADDR_CMPA_LO : ADDR_CMPB_LO;
    logic wrStb;
    logic forceStb;
    logic flagClr;
    assign wrStb = dpWrite_r && dpAddr_r == LO_ADDR;
    assign forceStb = dpWrite_r && dpAddr_r == ADDR_FORCE && hwdata[FORCE_LSB + i] &&
      !mode.pwm;
    assign flagClr = (dpWrite_r && dpAddr_r == ADDR_FLAGS && hwdata[FLAG_CMP_LSB + i]) ||
      irqAck[i + 1];
    tcc_compare_channel #(
      .W(CNT_W)
    ) u_ch (
      .clk(clk),
      .srst(srst),
      .counterValue(counterValue),
      .timerTick(timerTick),
      .atTop(atTop),
      .atBottom(atBottom),
      .mode(mode),
      .comMode(i == 0 ? ctrl_r.comModeA : ctrl_r.comModeB),
      .wrStb(wrStb),
      .wrValue(wrLowValue),
      .forceStb(forceStb),
      .blockMatch(block_r),
      .flagClr(flagClr),
      .compareValue(cmpValue[i]),
      .readValue(cmpRead[i]),
      .matchPulse(cmpMatch[i]),
      .flag(cmpFlag[i]),
      .outState(cmpOut[i])
    );
  end
  assign compareMatch = cmpMatch;
  assign compareOutputState = cmpOut;

  // interrupt requests towards the CPU
  assign irqRequest[0] = capFlag_r && ctrl_r.irqEnable[0];
  assign irqRequest[1] = cmpFlag[0] && ctrl_r.irqEnable[1];
  assign irqRequest[2] = cmpFlag[1] && ctrl_r.irqEnable[2];

  // read data selection in the address phase
  always_comb begin
    rdNxt = '0;
    case (ahbReq.haddr)
      ADDR_CTRL: begin
        rdNxt[CTRL_MODE_LSB +: 4] = ctrl_r.waveMode;
        rdNxt[CTRL_FILT_BIT] = ctrl_r.filterEnable;
        rdNxt[CTRL_EDGE_BIT] = ctrl_r.edgeRising;
        rdNxt[CTRL_CSEL_BIT] = ctrl_r.compSelect;
        rdNxt[CTRL_COMA_LSB +: 2] = ctrl_r.comModeA;
        rdNxt[CTRL_COMB_LSB +: 2] = ctrl_r.comModeB;
        rdNxt[CTRL_IEN_LSB +: 3] = ctrl_r.irqEnable;
      end
      ADDR_CNT_LO: rdNxt[7:0] = counterValue[7:0];
      ADDR_CNT_HI: rdNxt[7:0] = hiLatch_r;
      ADDR_CAP_LO: rdNxt[7:0] = capValue_r[7:0];
      ADDR_CAP_HI: rdNxt[7:0] = hiLatch_r;
      ADDR_CMPA_LO: rdNxt[7:0] = cmpRead[0][7:0];
      ADDR_CMPA_HI: rdNxt[7:0] = cmpRead[0][15:8];
      ADDR_CMPB_LO: rdNxt[7:0] = cmpRead[1][7:0];
      ADDR_CMPB_HI: rdNxt[7:0] = cmpRead[1][15:8];
      ADDR_FLAGS: begin
        rdNxt[FLAG_CAP_BIT] = capFlag_r;
        rdNxt[FLAG_CMP_LSB +: 2] = cmpFlag;
        rdNxt[FLAG_OUT_LSB +: 2] = cmpOut;
      end
      default: rdNxt = '0;
    endcase
  end

  // registered read data, valid in the data phase
  always_ff @(posedge clk) begin
    if (srst) hrdata_r <= '0;
    else if (rdAccept) hrdata_r <= rdNxt;
  end
  assign hrdata = hrdata_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence capLowThenHigh;
    rdCapLo ##1 !addrAccept ##1 (rdAccept && ahbReq.haddr == ADDR_CAP_HI);
  endsequence
  capture_copy_a: assert property (capEvent |=> capValue_r == $past(counterValue))
    else $error("capture did not copy the counter");
  capture_flag_a: assert property (capEvent |=> capFlag_r)
    else $error("capture flag not set with the copy");
  flag_clear_a: assert property (capClr && !capEvent |=> !capFlag_r)
    else $error("capture flag not cleared");
  latch_read_a: assert property (capLowThenHigh |=>
    hrdata_r[7:0] == $past(capValue_r[15:8], 3))
    else $error("high byte read did not return latched value");
  ceiling_write_a: assert property (dpWrite_r && dpAddr_r == ADDR_CAP_LO && !mode.topFromCap
    && !capEvent |=> $stable(capValue_r)) else $error("capture value written outside ceiling modes");
  input_off_a: assert property (mode.topFromCap |-> !capEvent)
    else $error("capture in a capture-ceiling mode");
  write_blocks_a: assert property (cntWrStb_r |=> block_r)
    else $error("counter write did not block matches");
  ceiling_miss_a: assert property (cntWrStb_r |=> !ceilingMatch)
    else $error("ceiling match not suppressed after counter write");
endmodule
`default_nettype wire

// >>> hdl/tcc_compare_channel.sv
// one compare channel: compare value with buffer, match flag and output state
`timescale 1ns/1ns
`default_nettype none
module tcc_compare_channel #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] counterValue,
  input wire logic timerTick,
  input wire logic atTop,
  input wire logic atBottom,
  input wire tcc_pkg::tcc_mode_t mode,
  input wire logic [1:0] comMode,
  input wire logic wrStb,
  input wire logic [W-1:0] wrValue,
  input wire logic forceStb,
  input wire logic blockMatch,
  input wire logic flagClr,
  output logic [W-1:0] compareValue,
  output logic [W-1:0] readValue,
  output logic matchPulse,
  output logic flag,
  output logic outState
);
  import tcc_pkg::*;
  logic [W-1:0] cmp_r;
  logic [W-1:0] buf_r;
  logic armed_r;
  logic flag_r;
  logic out_r;
  logic outNxt;
  logic transfer;
  if (W < 2) begin : g_chk
    $error("tcc_compare_channel width too small");
  end
  assign transfer = mode.pwm && timerTick && (mode.updBottom ? atBottom : atTop);
  // compare register and its buffer
  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_r <= '0;
      buf_r <= '0;
    end else begin
      if (wrStb) buf_r <= wrValue;
      if (wrStb && !mode.pwm) cmp_r <= wrValue;
      else if (transfer) cmp_r <= buf_r;
    end
  end
  // match seen at one tick is acted on at the next
  always_ff @(posedge clk) begin
    if (srst) armed_r <= 1'b0;
    else if (timerTick) armed_r <= (counterValue == cmp_r) && !blockMatch;
  end
  assign matchPulse = timerTick && armed_r;
  // sticky flag, a new match wins over a clear
  always_ff @(posedge clk) begin
    if (srst) flag_r <= 1'b0;
    else if (matchPulse) flag_r <= 1'b1;
    else if (flagClr) flag_r <= 1'b0;
  end
  // output state action, mode bits used unbuffered
  always_comb begin
    outNxt = out_r;
    if (!mode.pwm) begin
      if (matchPulse || forceStb) begin
        case (comMode)
          COM_TOGGLE: outNxt = !out_r;
          COM_CLEAR: outNxt = 1'b0;
          COM_SET: outNxt = 1'b1;
          default: outNxt = out_r;
        endcase
      end
    end else begin
      if (mode.fast && timerTick && atBottom && comMode[1]) outNxt = !comMode[0];
      if (matchPulse && comMode[1]) outNxt = comMode[0];
    end
  end
  // output state survives mode changes
  always_ff @(posedge clk) begin
    if (srst) out_r <= OUT_STATE_RESET;
    else out_r <= outNxt;
  end
  assign compareValue = cmp_r;
  assign readValue = mode.pwm ? buf_r : cmp_r;
  assign flag = flag_r;
  assign outState = out_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  flag_on_match_a: assert property (matchPulse |=> flag_r)
    else $error("match did not set the flag");
  match_blocked_a: assert property (blockMatch && timerTick |=> !armed_r)
    else $error("blocked match was armed");
  direct_write_a: assert property (wrStb && !mode.pwm |=> cmp_r == $past(wrValue))
    else $error("unbuffered write missed compare value");
  buffered_write_a: assert property (wrStb && mode.pwm && !transfer
    |=> $stable(cmp_r) && buf_r == $past(wrValue)) else $error("buffered write leaked");
  force_no_flag_a: assert property (forceStb && !matchPulse && !flag_r |=> !flag_r)
    else $error("force set the flag");
  keep_state_a: assert property (!matchPulse && !forceStb && !timerTick |=> $stable(out_r))
    else $error("output state changed without cause");
endmodule
`default_nettype wire

// >>> hdl/tcc_noise_filter.sv
// digital noise filter: output follows the input only after equal consecutive samples
`timescale 1ns/1ns
`default_nettype none
module tcc_noise_filter #(
  parameter int SAMPLES = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sampleIn,
  output logic filtOut
);
  import tcc_pkg::*;
  logic [SAMPLES-2:0] hist_r;
  logic filt_r;
  // the history slice below needs at least two stored samples
  if (SAMPLES < 3) begin : g_chk
    $error("tcc_noise_filter needs at least three samples");
  end
  // sample history and output update on unanimous samples
  always_ff @(posedge clk) begin
    if (srst) begin
      hist_r <= '0;
      filt_r <= 1'b0;
    end else begin
      hist_r <= {hist_r[SAMPLES-3:0], sampleIn};
      if (&{hist_r, sampleIn}) filt_r <= 1'b1;
      else if (!(|{hist_r, sampleIn})) filt_r <= 1'b0;
    end
  end
  assign filtOut = filt_r;
  sequence steadyHigh;
    sampleIn [*4];
  endsequence
  filter_rise_a: assert property (@(posedge clk) disable iff (srst || SAMPLES != 4)
    steadyHigh |=> filt_r) else $error("filter did not follow four high samples");
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the capture/compare block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import tcc_pkg::*;
  logic clk, srst, hready, hreadyout, hresp, timerTick, tickEn, capturePin, comparatorOutput;
  logic counterWriteStb, ceilingMatch;
  logic [31:0] hwdata, hrdata;
  logic [15:0] counterValue, counterWriteValue;
  logic [2:0] irqAck, irqRequest;
  logic [1:0] compareMatch, compareOutputState;
  tcc_ahb_req_t ahbReq;
  int fail_count = 0;
  int checks = 0;
  logic [31:0] q;
  assign hready = hreadyout;
  tcc_capture_compare tcc_capture_compare_i (.clk(clk), .srst(srst), .ahbReq(ahbReq),
    .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .counterValue(counterValue), .timerTick(timerTick), .capturePin(capturePin),
    .comparatorOutput(comparatorOutput), .irqAck(irqAck), .irqRequest(irqRequest),
    .counterWriteStb(counterWriteStb), .counterWriteValue(counterWriteValue),
    .ceilingMatch(ceilingMatch), .compareMatch(compareMatch),
    .compareOutputState(compareOutputState));
  tcc_counter_model tcc_counter_model_i (.clk(clk), .srst(srst), .timerTick(timerTick),
    .loadStb(counterWriteStb), .loadValue(counterWriteValue), .clearStb(ceilingMatch),
    .count(counterValue));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // timer tick every cycle while enabled
  always @(posedge clk) timerTick <= tickEn;
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask
  // one ahb single transfer: address phase, then data phase
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    ahbReq <= '{1'b1, 2'h2, w, 3'h2, a};
    waitRdy();
    ahbReq <= '{1'b0, 2'h0, 1'b0, 3'h2, a};
    hwdata <= d;
    waitRdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), exp, q);
  endtask
  // high byte first, then low byte
  task automatic w16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo + 8'h04, {24'h0, v[15:8]});
    wr(lo, {24'h0, v[7:0]});
  endtask
  task automatic waitIrq(input int b);
    int n;
    n = 0;
    while (irqRequest[b] !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("irqRequest", 32'h1, {31'h0, irqRequest[b]});
    if (irqRequest[b] !== 1'b1) stop_test();
  endtask
  // main sequence
  initial begin
    srst = 1'b1;
    ahbReq = '0;
    hwdata = 32'h0;
    tickEn = 1'b0;
    capturePin = 1'b0;
    comparatorOutput = 1'b0;
    irqAck = 3'h0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdChk(ADDR_FLAGS, 32'h0);
    rdChk(8'h2C, 32'h0);
    wr(ADDR_CTRL, 32'h7120);
    w16(ADDR_CNT_LO, 16'h1234);
    @(posedge clk); // counter loads one cycle after the write strobe
    rdChk(ADDR_CNT_LO, 32'h34);
    rdChk(ADDR_CNT_HI, 32'h12);
    capturePin <= 1'b1;
    waitIrq(0);
    rdChk(ADDR_FLAGS, 32'h1);
    rdChk(ADDR_CAP_LO, 32'h34);
    rdChk(ADDR_CAP_HI, 32'h12);
    wr(ADDR_CTRL, 32'h7100);
    w16(ADDR_CNT_LO, 16'h0456);
    capturePin <= 1'b0;
    repeat (8) @(posedge clk);
    rdChk(ADDR_CAP_LO, 32'h56);
    rdChk(ADDR_CAP_HI, 32'h04);
    wr(ADDR_FLAGS, 32'h1);
    capturePin <= 1'b1;
    repeat (8) @(posedge clk);
    chk("irqRequest", 32'h0, {29'h0, irqRequest});
    capturePin <= 1'b0;
    repeat (10) @(posedge clk);
    chk("irqRequest", 32'h1, {29'h0, irqRequest});
    wr(ADDR_FLAGS, 32'h1);
    wr(ADDR_CTRL, 32'h7130);
    capturePin <= 1'b1;
    repeat (2) @(posedge clk);
    capturePin <= 1'b0;
    repeat (12) @(posedge clk);
    chk("irqRequest", 32'h0, {29'h0, irqRequest});
    capturePin <= 1'b1;
    waitIrq(0);
    irqAck <= 3'h1;
    @(posedge clk);
    irqAck <= 3'h0;
    @(posedge clk);
    chk("irqRequest", 32'h0, {29'h0, irqRequest});
    wr(ADDR_CTRL, 32'h7160);
    wr(ADDR_FLAGS, 32'h1);
    comparatorOutput <= 1'b1;
    waitIrq(0);
    wr(ADDR_FLAGS, 32'h1);
    w16(ADDR_CMPA_LO, 16'h0120);
    w16(ADDR_CAP_LO, 16'h7777);
    rdChk(ADDR_CAP_LO, 32'h56);
    rdChk(ADDR_CMPA_HI, 32'h01);
    rdChk(ADDR_CMPA_LO, 32'h20);
    wr(ADDR_FORCE, 32'h1);
    rdChk(ADDR_FLAGS, 32'h10);
    w16(ADDR_CNT_LO, 16'h0118);
    tickEn <= 1'b1;
    waitIrq(1);
    tickEn <= 1'b0;
    rdChk(ADDR_FLAGS, 32'h02);
    wr(ADDR_FLAGS, 32'h2);
    tickEn <= 1'b1;
    w16(ADDR_CNT_LO, 16'h0120);
    repeat (6) @(posedge clk);
    tickEn <= 1'b0;
    rdChk(ADDR_FLAGS, 32'h0);
    // fast pwm with capture ceiling: buffered compare, capture input off
    wr(ADDR_CTRL, 32'h710E);
    w16(ADDR_CAP_LO, 16'h0130);
    rdChk(ADDR_CAP_LO, 32'h30);
    rdChk(ADDR_CAP_HI, 32'h01);
    w16(ADDR_CMPA_LO, 16'h0128);
    rdChk(ADDR_CMPA_LO, 32'h28);
    capturePin <= 1'b0;
    tickEn <= 1'b1;
    repeat (6) @(posedge clk);
    tickEn <= 1'b0;
    rdChk(ADDR_FLAGS, 32'h0);
    // run through the ceiling so the counter wraps and channel b matches zero
    tickEn <= 1'b1;
    repeat (20) @(posedge clk);
    tickEn <= 1'b0;
    @(posedge clk);
    acc(1'b0, ADDR_CNT_LO, 32'h0, q);
    rdChk(ADDR_CNT_HI, 32'h0);
    rdChk(ADDR_FLAGS, 32'h04);
    chk("irqRequest", 32'h4, {29'h0, irqRequest});
    stop_test();
  end
endmodule
`default_nettype wire

// >>> verification/tcc_counter_model.sv
// external 16-bit counter model driven by the block's load and clear strobes
`timescale 1ns/1ns
`default_nettype none
module tcc_counter_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic timerTick,
  input wire logic loadStb,
  input wire logic [15:0] loadValue,
  input wire logic clearStb,
  output logic [15:0] count
);
  // cpu load beats clear and count
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= 16'h0000;
    end else if (loadStb) begin
      count <= loadValue;
    end else if (clearStb) begin
      count <= 16'h0000;
    end else if (timerTick) begin
      count <= count + 16'h0001;
    end
  end
endmodule
`default_nettype wire
